//--- design/xfde_pkg.sv
// Constants and types shared by the instruction decoder files
package xfde_pkg;
   localparam int PC_W      = 21;
   localparam int DADDR_W   = 12;
   localparam int STK_DEPTH = 31;
   localparam int DMEM_SIZE = 4096;

   localparam logic [5:0]  XOR_OPC    = 6'h06;
   localparam logic [7:0]  ADDP_OPC   = 8'he8;
   localparam logic [7:0]  SUBP_OPC   = 8'he9;
   localparam logic [7:0]  PUSH_LITERAL_OPC  = 8'hea;
   localparam logic [7:0]  MOVS_OPC   = 8'heb;
   localparam logic [15:0] CALL_VIA_WORKING_REG_WORD = 16'h0014;
   localparam logic [15:0] NOP_WORD   = 16'h0000;
   localparam logic [3:0]  SECOND_TAG = 4'hf;
   localparam logic [1:0]  PTR_TWO_SEL = 2'h3;
   localparam int          PTR_TWO    = 2;
   localparam logic [7:0]  IDX_LIMIT  = 8'h5f;
   localparam logic [3:0]  ACC_LO_BANK = 4'h0;
   localparam logic [3:0]  ACC_HI_BANK = 4'hf;
   localparam logic [20:0] PC_STEP    = 21'h000002;
   localparam logic [1:0]  CFG_SETTLE = 2'h2;

   localparam logic [3:0] REG_CTRL   = 4'h0;
   localparam logic [3:0] REG_WORKING_REG   = 4'h1;
   localparam logic [3:0] REG_BSR    = 4'h2;
   localparam logic [3:0] REG_STATUS = 4'h3;
   localparam logic [3:0] REG_PTR0   = 4'h4;
   localparam logic [3:0] REG_PTR1   = 4'h5;
   localparam logic [3:0] REG_PTR2   = 4'h6;
   localparam logic [3:0] REG_PC     = 4'h7;
   localparam logic [3:0] REG_LATCH  = 4'h8;
   localparam logic [3:0] REG_TOS    = 4'h9;
   localparam logic [3:0] REG_STATE  = 4'ha;
   localparam logic [3:0] REG_MADDR  = 4'hb;
   localparam logic [3:0] REG_MDATA  = 4'hc;

   localparam int CTRL_RUN_BIT  = 0;
   localparam int CTRL_EXT_BIT  = 1;
   localparam int STATUS_N_BIT  = 4;
   localparam int STATUS_Z_BIT  = 2;
   localparam int LATCH_UPPER_LSB = 8;

   typedef enum logic [1:0] {PH_Q1, PH_Q2, PH_Q3, PH_Q4} xfde_phase_e;
   typedef enum logic [1:0] {SEC_NONE, SEC_NOP, SEC_MOVE} xfde_sec_e;
   typedef enum logic [3:0] {OP_NOP, OP_XOR, OP_ADDP, OP_SUBP, OP_ADDRET,
                             OP_SUBRET, OP_CALL_VIA_WORKING_REG, OP_MOVS, OP_PUSH_LITERAL} xfde_op_e;
endpackage

//--- design/xfde_dmem_if.sv
// Data memory port between the core and its file storage
`timescale 1ns/100ps
interface xfde_dmem_if #(parameter int AW = 12);
   logic [AW-1:0] addr;
   logic [7:0]    wdata;
   logic          we;
   logic [7:0]    rdata;
   modport core (output addr, output wdata, output we, input rdata);
   modport mem  (input addr, input wdata, input we, output rdata);
endinterface

//--- design/xfde_dmem.sv
// File register storage with combinational read
`timescale 1ns/100ps
module xfde_dmem #(
   parameter int DEPTH = xfde_pkg::DMEM_SIZE
) (
   input wire logic    sys_clk,
   xfde_dmem_if.mem    port
);
   logic [7:0] store [DEPTH];

   always_ff @(posedge sys_clk) begin
      if (port.we) begin
         store[port.addr] <= port.wdata;
      end
   end

   assign port.rdata = store[port.addr];
endmodule

//--- design/xfde_stack.sv
// Return address stack
`timescale 1ns/100ps
module xfde_stack #(
   parameter int DEPTH = xfde_pkg::STK_DEPTH,
   parameter int W     = xfde_pkg::PC_W,
   parameter int LW    = $clog2(DEPTH + 1)
) (
   input  wire logic          sys_clk,
   input  wire logic          rst_n,
   input  wire logic          push,
   input  wire logic          pop,
   input  wire logic [W-1:0]  push_data,
   output logic      [W-1:0]  top_of_stack,
   output logic      [LW-1:0] level
);
   typedef struct packed {
      logic [LW-1:0] level;
   } xfde_stk_s;

   xfde_stk_s   st_r;
   xfde_stk_s   st_nxt;
   logic [W-1:0] slot [DEPTH];
   logic        full;

   assign full = (st_r.level == LW'(DEPTH));

   always_comb begin
      st_nxt = st_r;
      if (push && !full) begin
         st_nxt.level = st_r.level + 1'b1;
      end else if (pop && st_r.level != '0) begin
         st_nxt.level = st_r.level - 1'b1;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
      if (push && !full) begin
         slot[st_r.level] <= push_data;
      end
   end

   assign top_of_stack   = (st_r.level == '0) ? '0 : slot[st_r.level - 1'b1];
   assign level = st_r.level;
endmodule

//--- design/xfde_core.sv
// Decode and execute of xor-with-file and the extended instruction group
//
// Our own choices: strobed register access and the placing of the registers.
`timescale 1ns/100ps
module xfde_core (
   input  wire logic                       sys_clk,
   input  wire logic                       rst_n,
   input  wire logic                       cfg_ext_enable,
   output logic      [xfde_pkg::PC_W-1:0]  prog_addr,
   input  wire logic [15:0]                prog_data,
   input  wire logic [3:0]                 bus_addr,
   input  wire logic [31:0]                bus_wdata,
   input  wire logic                       bus_wr,
   input  wire logic                       bus_rd,
   output logic      [31:0]                bus_rdata
);
   import xfde_pkg::*;

   typedef struct packed {
      xfde_phase_e       phase;
      logic              run;
      logic [1:0]        cfg_sync;
      logic [1:0]        cfg_cnt;
      logic              cfg_taken;
      logic              ext_en;
      logic [15:0]       ir;
      logic [15:0]       ir2;
      xfde_sec_e         sec;
      logic [PC_W-1:0]   pc;
      logic [7:0]        working_reg;
      logic [7:0]        opnd;
      logic [3:0]        bank_select_reg;
      logic              neg;
      logic              zero;
      logic [2:0][11:0]  ptr;
      logic [7:0]        pc_high_latch;
      logic [4:0]        pc_upper_latch;
      logic [11:0]       maddr;
      logic [31:0]       rdata;
   } xfde_state_s;

   xfde_state_s       r;
   xfde_state_s       n;
   xfde_op_e          op;
   logic [31:0]       rd_val;
   logic              stk_push;
   logic              stk_pop;
   logic [PC_W-1:0]   stk_tos;
   logic [4:0]        stk_level;

   xfde_dmem_if #(.AW(DADDR_W)) dm ();

   xfde_dmem u_dmem (
      .sys_clk (sys_clk),
      .port    (dm.mem)
   );

   xfde_stack u_stack (
      .sys_clk   (sys_clk),
      .rst_n     (rst_n),
      .push      (stk_push),
      .pop       (stk_pop),
      .push_data (r.pc),
      .top_of_stack       (stk_tos),
      .level     (stk_level)
   );

   function automatic xfde_op_e op_decode(input logic [15:0] w,
                                          input logic        ext);
      op_decode = OP_NOP;
      if (w[15:10] == XOR_OPC) begin
         op_decode = OP_XOR;
      end else if (ext) begin
         if (w == CALL_VIA_WORKING_REG_WORD) begin
            op_decode = OP_CALL_VIA_WORKING_REG;
         end else begin
            case (w[15:8])
               ADDP_OPC:
                  op_decode = (w[7:6] == PTR_TWO_SEL) ? OP_ADDRET : OP_ADDP;
               SUBP_OPC:
                  op_decode = (w[7:6] == PTR_TWO_SEL) ? OP_SUBRET : OP_SUBP;
               PUSH_LITERAL_OPC: op_decode = OP_PUSH_LITERAL;
               MOVS_OPC:  op_decode = OP_MOVS;
               default:   op_decode = OP_NOP;
            endcase
         end
      end
   endfunction

   function automatic logic [11:0] idx_addr(input logic [11:0] base,
                                            input logic [7:0]  off);
      idx_addr = base + {4'h0, off};
   endfunction

   function automatic logic [11:0] file_addr(input logic [7:0]  f,
                                             input logic        a,
                                             input logic        ext,
                                             input logic [3:0]  bank_select_reg,
                                             input logic [11:0] p2);
      if (a) begin
         file_addr = {bank_select_reg, f};
      end else if (ext && f <= IDX_LIMIT) begin
         file_addr = idx_addr(p2, f);
      end else if (f <= IDX_LIMIT) begin
         file_addr = {ACC_LO_BANK, f};
      end else begin
         file_addr = {ACC_HI_BANK, f};
      end
   endfunction

   assign op = op_decode(r.ir, r.ext_en);

   always_comb begin
      unique case (bus_addr)
         REG_CTRL:   rd_val = 32'({r.ext_en, r.run});
         REG_WORKING_REG:   rd_val = 32'(r.working_reg);
         REG_BSR:    rd_val = 32'(r.bank_select_reg);
         REG_STATUS: rd_val = 32'({r.neg, 1'b0, r.zero, 2'b00});
         REG_PTR0:   rd_val = 32'(r.ptr[0]);
         REG_PTR1:   rd_val = 32'(r.ptr[1]);
         REG_PTR2:   rd_val = 32'(r.ptr[PTR_TWO]);
         REG_PC:     rd_val = 32'(r.pc);
         REG_LATCH:  rd_val = 32'({r.pc_upper_latch, r.pc_high_latch});
         REG_TOS:    rd_val = 32'(stk_tos);
         REG_STATE:  rd_val = 32'({stk_level, r.sec, r.phase});
         REG_MADDR:  rd_val = 32'(r.maddr);
         REG_MDATA:  rd_val = 32'(dm.rdata);
         default:    rd_val = 32'h0000_0000;
      endcase
   end

   always_comb begin
      n          = r;
      dm.addr    = r.maddr;
      dm.we      = 1'b0;
      dm.wdata   = bus_wdata[7:0];
      stk_push   = 1'b0;
      stk_pop    = 1'b0;
      n.cfg_sync = {r.cfg_sync[0], cfg_ext_enable};
      if (r.cfg_cnt != CFG_SETTLE) begin
         n.cfg_cnt = r.cfg_cnt + 1'b1;
      end else if (!r.cfg_taken) begin
         n.ext_en    = r.cfg_sync[1];
         n.cfg_taken = 1'b1;
      end
      if (r.run) begin
         unique case (r.phase)
            PH_Q1: n.phase = PH_Q2;
            PH_Q2: n.phase = PH_Q3;
            PH_Q3: n.phase = PH_Q4;
            PH_Q4: n.phase = PH_Q1;
         endcase
         if (r.phase == PH_Q4) begin
            n.ir  = prog_data;
            n.pc  = r.pc + PC_STEP;
            n.sec = SEC_NONE;
         end
         if (r.sec == SEC_NONE) begin
            unique case (op)
               OP_XOR: begin
                  dm.addr = file_addr(r.ir[7:0], r.ir[8], r.ext_en,
                                      r.bank_select_reg, r.ptr[PTR_TWO]);
                  if (r.phase == PH_Q2) begin
                     n.opnd = r.working_reg ^ dm.rdata;
                  end
                  if (r.phase == PH_Q3) begin
                     n.neg  = r.opnd[7];
                     n.zero = (r.opnd == 8'h00);
                  end
                  if (r.phase == PH_Q4) begin
                     if (r.ir[9]) begin
                        dm.we    = 1'b1;
                        dm.wdata = r.opnd;
                     end else begin
                        n.working_reg = r.opnd;
                     end
                  end
               end
               OP_ADDP: begin
                  if (r.phase == PH_Q4) begin
                     n.ptr[r.ir[7:6]] = r.ptr[r.ir[7:6]] + {6'h00, r.ir[5:0]};
                  end
               end
               OP_SUBP: begin
                  if (r.phase == PH_Q4) begin
                     n.ptr[r.ir[7:6]] = r.ptr[r.ir[7:6]] - {6'h00, r.ir[5:0]};
                  end
               end
               OP_ADDRET, OP_SUBRET: begin
                  if (r.phase == PH_Q4) begin
                     if (op == OP_ADDRET) begin
                        n.ptr[PTR_TWO] = r.ptr[PTR_TWO] + {6'h00, r.ir[5:0]};
                     end else begin
                        n.ptr[PTR_TWO] = r.ptr[PTR_TWO] - {6'h00, r.ir[5:0]};
                     end
                     n.pc    = stk_tos;
                     stk_pop = 1'b1;
                     n.ir    = NOP_WORD;
                     n.sec   = SEC_NOP;
                  end
               end
               OP_CALL_VIA_WORKING_REG: begin
                  if (r.phase == PH_Q4) begin
                     stk_push = 1'b1;
                     n.pc     = {r.pc_upper_latch, r.pc_high_latch, r.working_reg};
                     n.ir     = NOP_WORD;
                     n.sec    = SEC_NOP;
                  end
               end
               OP_PUSH_LITERAL: begin
                  if (r.phase == PH_Q4) begin
                     dm.addr        = r.ptr[PTR_TWO];
                     dm.we          = 1'b1;
                     dm.wdata       = r.ir[7:0];
                     n.ptr[PTR_TWO] = r.ptr[PTR_TWO] - 12'h001;
                  end
               end
               OP_MOVS: begin
                  if (r.phase == PH_Q4) begin
                     n.ir2 = prog_data;
                     n.ir  = r.ir;
                     n.sec = SEC_MOVE;
                  end
               end
               OP_NOP: begin
               end
            endcase
         end else if (r.sec == SEC_MOVE) begin
            dm.addr = idx_addr(r.ptr[PTR_TWO], {1'b0, r.ir[6:0]});
            if (r.phase == PH_Q2) begin
               n.opnd = dm.rdata;
            end
            if (r.phase == PH_Q4 && r.ir2[15:12] == SECOND_TAG) begin
               dm.we    = 1'b1;
               dm.wdata = r.opnd;
               if (r.ir[7]) begin
                  dm.addr = idx_addr(r.ptr[PTR_TWO], {1'b0, r.ir2[6:0]});
               end else begin
                  dm.addr = r.ir2[11:0];
               end
            end
         end
      end
      if (bus_wr) begin
         unique case (bus_addr)
            REG_CTRL:   n.run = bus_wdata[CTRL_RUN_BIT];
            REG_WORKING_REG:   n.working_reg = bus_wdata[7:0];
            REG_BSR:    n.bank_select_reg = bus_wdata[3:0];
            REG_STATUS: begin
               n.neg  = bus_wdata[STATUS_N_BIT];
               n.zero = bus_wdata[STATUS_Z_BIT];
            end
            REG_PTR0:   n.ptr[0] = bus_wdata[11:0];
            REG_PTR1:   n.ptr[1] = bus_wdata[11:0];
            REG_PTR2:   n.ptr[PTR_TWO] = bus_wdata[11:0];
            REG_PC:     n.pc = bus_wdata[PC_W-1:0];
            REG_LATCH:  begin
               n.pc_high_latch = bus_wdata[7:0];
               n.pc_upper_latch = bus_wdata[LATCH_UPPER_LSB +: 5];
            end
            REG_MADDR:  n.maddr = bus_wdata[11:0];
            REG_MDATA:  begin
               if (!r.run) begin
                  dm.we = 1'b1;
               end
            end
            default:    ;
         endcase
      end
      n.rdata = bus_rd ? rd_val : 32'h0000_0000;
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         r        <= '0;
         r.ext_en <= 1'b1;
      end else begin
         r <= n;
      end
   end

   assign prog_addr = r.pc;
   assign bus_rdata = r.rdata;
endmodule

//--- bench/xfde_core_asserts.sv
// Fetch timing checks on the decoder core ports
`timescale 1ns/100ps
module xfde_core_asserts (
   input wire logic                      sys_clk,
   input wire logic                      rst_n,
   input wire logic                      cfg_ext_enable,
   input wire logic [xfde_pkg::PC_W-1:0] prog_addr,
   input wire logic [15:0]               prog_data,
   input wire logic [3:0]                bus_addr,
   input wire logic [31:0]               bus_wdata,
   input wire logic                      bus_wr,
   input wire logic                      bus_rd,
   input wire logic [31:0]               bus_rdata
);
   import xfde_pkg::*;
   logic [PC_W-1:0] pa_q;
   logic [PC_W-1:0] pa_r;
   logic [15:0]     pd_q;
   logic [15:0]     ex_r;
   logic            wr_q;
   logic            first_r;
   logic [2:0]      cnt_r;
   logic            bnd;
   logic            is_ptr;
   logic            is_ret;
   logic            is_call;
   logic            is_mv;
   // Cycle boundary: fetch address moved by the core itself
   assign bnd = (prog_addr != pa_q) && !wr_q;
   assign is_ptr = ex_r[15:9] == ADDP_OPC[7:1];
   assign is_ret = cfg_ext_enable && is_ptr && ex_r[7:6] == PTR_TWO_SEL;
   assign is_call = cfg_ext_enable && ex_r == CALL_VIA_WORKING_REG_WORD;
   assign is_mv = cfg_ext_enable && ex_r[15:8] == MOVS_OPC;
   always_ff @(posedge sys_clk) begin
      pa_q <= prog_addr;
      pd_q <= prog_data;
      wr_q <= bus_wr;
      if (!rst_n || bus_wr) begin
         first_r <= 1'b1;
         cnt_r   <= 3'h0;
         ex_r    <= NOP_WORD;
         pa_r    <= prog_addr;
      end else if (bnd) begin
         first_r <= 1'b0;
         cnt_r   <= 3'h0;
         pa_r    <= prog_addr;
         ex_r    <= (is_ret || is_call || is_mv) ? NOP_WORD : pd_q;
      end else if (cnt_r != 3'h7) begin
         cnt_r <= cnt_r + 3'h1;
      end
   end
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!rst_n);
   sequence edge_s(k);
      bnd && !first_r && k;
   endsequence
   sequence nop_cyc_s;
      (!bnd && !bus_wr)[*3] ##1 bnd;
   endsequence
   property step_p(k);
      edge_s(k) |-> prog_addr == pa_r + PC_STEP;
   endproperty
   property two_p(k);
      edge_s(k) |=> nop_cyc_s ##0 prog_addr == pa_r + PC_STEP;
   endproperty
   cycle_len_a: assert property (bnd && !first_r |-> cnt_r == 3'h3)
      else $error("instruction cycle not four clocks");
   xor_step_a: assert property (step_p(ex_r[15:10] == XOR_OPC))
      else $error("xor not one word");
   ptr_step_a: assert property (step_p(is_ptr && ex_r[7:6] != 2'h3))
      else $error("pointer op not one cycle");
   push_step_a: assert property (step_p(ex_r[15:8] == PUSH_LITERAL_OPC))
      else $error("push not one cycle");
   ext_off_a: assert property (step_p(!cfg_ext_enable))
      else $error("flow change with extension off");
   ret_seq_a: assert property (two_p(is_ret))
      else $error("return variant not two cycles");
   call_seq_a: assert property (two_p(is_call))
      else $error("call not two cycles");
   mv_step_a: assert property (step_p(is_mv))
      else $error("move did not fetch second word");
   mv_seq_a: assert property (two_p(is_mv))
      else $error("move second word not consumed");
endmodule
bind xfde_core xfde_core_asserts xfde_core_asserts_i (
   .sys_clk(sys_clk), .rst_n(rst_n), .cfg_ext_enable(cfg_ext_enable),
   .prog_addr(prog_addr), .prog_data(prog_data), .bus_addr(bus_addr),
   .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd),
   .bus_rdata(bus_rdata));

//--- bench/xfde_pmem.sv
// Program memory model answering the fetch address
`timescale 1ns/100ps
module xfde_pmem (
   input wire logic [xfde_pkg::PC_W-1:0] prog_addr,
   output logic     [15:0]               prog_data
);
   import xfde_pkg::*;
   logic [15:0] mem [0:63];
   // Upper address bits alias onto the 64-word image
   assign prog_data = mem[prog_addr[6:1]];
endmodule

//--- bench/xor_file_and_extended_ops_decoder_tb_top.sv
// Self-checking bench for the decoder core
`timescale 1ns/100ps
module xor_file_and_extended_ops_decoder_tb_top;
   import xfde_pkg::*;
   logic            sys_clk;
   logic            rst_n;
   logic            cfg_ext_enable;
   logic [PC_W-1:0] prog_addr;
   logic [15:0]     prog_data;
   logic [3:0]      bus_addr;
   logic [31:0]     bus_wdata;
   logic            bus_wr;
   logic            bus_rd;
   logic [31:0]     bus_rdata;
   int              fail_count;
   int              n_checks;
   int              cyc;
   xfde_core xfde_core_i (.sys_clk(sys_clk), .rst_n(rst_n),
      .cfg_ext_enable(cfg_ext_enable), .prog_addr(prog_addr),
      .prog_data(prog_data), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
      .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata));
   xfde_pmem xfde_pmem_i (.prog_addr(prog_addr), .prog_data(prog_data));
   initial begin
      sys_clk = 1'b0;
      forever #4 sys_clk = ~sys_clk;
   end
   always @(posedge sys_clk) begin
      cyc++;
      if (cyc == 5000) begin
         fail_count++;
         stop_test();
      end
   end
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      bus_wr    <= 1'b1;
      bus_addr  <= a;
      bus_wdata <= d;
      @(posedge sys_clk);
      bus_wr <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, input logic [31:0] exp);
      @(posedge sys_clk);
      bus_rd   <= 1'b1;
      bus_addr <= a;
      @(posedge sys_clk);
      bus_rd <= 1'b0;
      @(negedge sys_clk);
      chk(bus_rdata, exp);
   endtask
   task automatic mwr(input logic [11:0] a, input logic [7:0] d);
      wr(REG_MADDR, {20'h0, a});
      wr(REG_MDATA, {24'h0, d});
   endtask
   task automatic mrd(input logic [11:0] a, input logic [7:0] exp);
      wr(REG_MADDR, {20'h0, a});
      rd(REG_MDATA, {24'h0, exp});
   endtask
   task automatic boot(input logic ext);
      @(posedge sys_clk);
      rst_n          <= 1'b0;
      cfg_ext_enable <= ext;
      repeat (16) @(posedge sys_clk);
      rst_n <= 1'b1;
      repeat (4) @(posedge sys_clk);
   endtask
   task automatic ld(input logic [15:0] w [$]);
      for (int i = 0; i < 64; i++) begin
         xfde_pmem_i.mem[i] = i < w.size() ? w[i] : NOP_WORD;
      end
   endtask
   task automatic run(input int n);
      wr(REG_CTRL, 32'h1);
      repeat (4 * n) @(posedge sys_clk);
      wr(REG_CTRL, 32'h0);
   endtask
   task automatic t_xor();
      boot(1'b1);
      rd(REG_CTRL, 32'h2);
      wr(REG_WORKING_REG, 32'hb5);
      wr(REG_PTR2, 32'h100);
      wr(REG_BSR, 32'h3);
      wr(REG_STATUS, 32'h1f);
      mwr(12'h120, 8'haf);
      mwr(12'h340, 8'hb5);
      mwr(12'hf60, 8'h80);
      ld({16'h1a20, 16'h1940, 16'h1860});
      run(3);
      mrd(12'h120, 8'h1a);
      rd(REG_WORKING_REG, 32'h0);
      rd(REG_STATUS, 32'h04);
      rd(REG_STATE, 32'h2);
      run(3);
      rd(REG_WORKING_REG, 32'h80);
      rd(REG_STATUS, 32'h10);
   endtask
   task automatic t_ptr();
      boot(1'b1);
      wr(REG_PTR0, 32'h3ff);
      wr(REG_PTR1, 32'h10);
      wr(REG_PTR2, 32'h200);
      wr(REG_STATUS, 32'h15);
      ld({16'he823, 16'he97f, 16'hea5a, 16'he883});
      run(6);
      rd(REG_PTR0, 32'h422);
      rd(REG_PTR1, 32'hfd1);
      rd(REG_PTR2, 32'h202);
      mrd(12'h200, 8'h5a);
      rd(REG_STATUS, 32'h14);
   endtask
   task automatic t_ret();
      logic [15:0] op [2] = '{16'he8c5, 16'he9c3};
      logic [31:0] res [2] = '{32'h105, 32'h0fd};
      for (int i = 0; i < 2; i++) begin
         boot(1'b1);
         wr(REG_WORKING_REG, 32'h20);
         wr(REG_LATCH, 32'h102);
         wr(REG_PTR2, 32'h100);
         ld({CALL_VIA_WORKING_REG_WORD});
         xfde_pmem_i.mem[16] = op[i];
         run(i == 0 ? 3 : 8);
         if (i == 0) begin
            rd(REG_PC, 32'h10222);
            rd(REG_TOS, 32'h2);
            rd(REG_STATE, 32'h12);
            run(5);
         end
         rd(REG_PTR2, res[i]);
         rd(REG_TOS, 32'h0);
      end
   endtask
   task automatic t_mov();
      boot(1'b1);
      wr(REG_PTR2, 32'h100);
      wr(REG_WORKING_REG, 32'h0f);
      mwr(12'h105, 8'h77);
      mwr(12'h10a, 8'h99);
      mwr(12'h120, 8'h33);
      mwr(12'ha20, 8'h00);
      ld({16'heb05, 16'hf234, 16'heb8a, 16'hf003, 16'heb05, 16'h1a20});
      run(8);
      mrd(12'h234, 8'h77);
      mrd(12'h103, 8'h99);
      mrd(12'ha20, 8'h00);
      mrd(12'h120, 8'h33);
      rd(REG_WORKING_REG, 32'h0f);
   endtask
   task automatic t_off();
      boot(1'b0);
      rd(REG_CTRL, 32'h0);
      rd(4'hd, 32'h0);
      wr(REG_PTR2, 32'h100);
      wr(REG_WORKING_REG, 32'h0f);
      mwr(12'h020, 8'hf0);
      mwr(12'h120, 8'h55);
      mwr(12'h100, 8'h00);
      ld({16'h1a20, CALL_VIA_WORKING_REG_WORD, 16'he8c5, 16'hea5a});
      run(6);
      mrd(12'h020, 8'hff);
      mrd(12'h120, 8'h55);
      mrd(12'h100, 8'h00);
      rd(REG_PTR2, 32'h100);
      rd(REG_TOS, 32'h0);
   endtask
   task automatic stop_test();
      $display("checks=%0d mismatches=%0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   initial begin
      rst_n          = 1'b0;
      cfg_ext_enable = 1'b1;
      bus_addr       = 4'h0;
      bus_wdata      = 32'h0;
      bus_wr         = 1'b0;
      bus_rd         = 1'b0;
      fail_count     = 0;
      n_checks       = 0;
      cyc            = 0;
      t_xor();
      t_ptr();
      t_ret();
      t_mov();
      t_off();
      stop_test();
   end
endmodule
